//--- logic/radio_modem_control.sv
// Modem control registers, clear channel, checksum, acknowledge timing and test data paths
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Transmit data queue
module data_queue #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic push;
	logic pop;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (count_ff != (AW+1)'(DEPTH));
	assign out_valid = (count_ff != '0);
	assign out_data = mem_ff[rd_ptr_ff];
	always_ff @(posedge clock)
	begin
		if (push)
			mem_ff[wr_ptr_ff] <= in_data;
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
			if (pop)
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
			count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// ==========================================================
// Top
module radio_modem_control
	import radio_modem_pkg::*;
#(
	parameter int QUEUE_DEPTH = 4
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [15:0] xdata_addr,
	input wire logic xdata_wr,
	input wire logic xdata_rd,
	input wire logic [7:0] xdata_wdata,
	output logic [7:0] xdata_rdata,
	input wire logic [2:0] clear_channel_hysteresis,
	input wire logic [7:0] clear_channel_threshold,
	input wire logic [7:0] rssi_value,
	input wire logic address_decode_enable,
	input wire logic address_match,
	output logic channel_clear,
	input wire logic tx_start,
	input wire logic tx_stop,
	input wire logic tx_in_valid,
	input wire logic [7:0] tx_in_data,
	input wire logic tx_in_last,
	output logic tx_in_ready,
	input wire logic tx_serial_pin,
	output logic tx_out_valid,
	output logic [7:0] tx_out_data,
	input wire logic tx_out_ready,
	output logic tx_active,
	input wire logic rx_in_sfd,
	input wire logic rx_in_valid,
	input wire logic [7:0] rx_in_data,
	input wire logic rx_in_last,
	input wire logic receive_queue_full,
	output logic rx_out_valid,
	output logic [7:0] rx_out_data,
	output logic rx_serial_pin,
	output logic rx_busy,
	output logic rx_frame_done,
	output logic rx_crc_ok,
	output logic rx_overflow,
	output logic ack_send,
	input wire logic [4:0] correlator_value,
	input wire logic preamble_match,
	output logic sfd_search_enable,
	output logic dc_level_frozen,
	output logic phase_reversed
);
	logic [7:0] mdm0l_ff;
	logic [7:0] mdm1h_ff;
	logic [5:0] mdm1l_ff;
	logic [1:0] cca_sel;
	logic [1:0] tx_test;
	logic [1:0] rx_test;
	logic slotted;
	assign cca_sel = mdm0l_ff[CCA_SEL_LSB +: 2];
	assign tx_test = mdm1l_ff[TX_TEST_LSB +: 2];
	assign rx_test = mdm1l_ff[1:0];
	assign slotted = mdm1h_ff[SLOTTED_ACK_BIT];

	function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] data);
		logic [15:0] c;
		c = crc;
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ data[i]) ? ((c >> 1) ^ CRC_POLY_REFLECTED) : (c >> 1);
		return c;
	endfunction

	// ==========================================================
	// Register bus
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mdm0l_ff <= RST_MODEM_CONTROL_0_LOW;
			mdm1h_ff <= RST_MODEM_CONTROL_1_HIGH;
			mdm1l_ff <= RST_MODEM_CONTROL_1_LOW[5:0];
		end
		else if (xdata_wr)
		begin
			if (xdata_addr == ADDR_MODEM_CONTROL_0_LOW)
				mdm0l_ff <= xdata_wdata;
			if (xdata_addr == ADDR_MODEM_CONTROL_1_HIGH)
				mdm1h_ff <= xdata_wdata;
			if (xdata_addr == ADDR_MODEM_CONTROL_1_LOW)
				mdm1l_ff <= xdata_wdata[5:0];
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			xdata_rdata <= 8'h00;
		else if (xdata_rd)
		begin
			unique case (xdata_addr)
				ADDR_MODEM_CONTROL_0_LOW: xdata_rdata <= mdm0l_ff;
				ADDR_MODEM_CONTROL_1_HIGH: xdata_rdata <= mdm1h_ff;
				ADDR_MODEM_CONTROL_1_LOW: xdata_rdata <= {2'h0, mdm1l_ff};
				default: xdata_rdata <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Clear channel assessment
	logic signed [9:0] rssi_s;
	logic signed [9:0] thr_s;
	logic signed [9:0] thr_low_s;
	logic rssi_clear_ff;
	logic nxt_rssi_clear;
	assign rssi_s = 10'(signed'(rssi_value));
	assign thr_s = 10'(signed'(clear_channel_threshold));
	assign thr_low_s = thr_s - signed'({7'h00, clear_channel_hysteresis});
	always_comb
	begin
		nxt_rssi_clear = rssi_clear_ff;
		if (rssi_s >= thr_s)
			nxt_rssi_clear = 1'b0;
		else if (rssi_s < thr_low_s)
			nxt_rssi_clear = 1'b1;
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rssi_clear_ff <= 1'b0;
			channel_clear <= 1'b0;
		end
		else
		begin
			rssi_clear_ff <= nxt_rssi_clear;
			unique case (cca_sel)
				CCA_RSSI: channel_clear <= nxt_rssi_clear;
				CCA_NO_RX: channel_clear <= !rx_busy;
				CCA_BOTH: channel_clear <= nxt_rssi_clear && !rx_busy;
				default: channel_clear <= 1'b0;
			endcase
		end
	end

	// ==========================================================
	// Transmit path
	logic q_valid;
	logic [8:0] q_data;
	logic q_pop;
	logic advance;
	logic [2:0] ser_sync_ff;
	logic ser_stable_ff;
	logic [7:0] ser_shift_ff;
	tx_state_t tx_state_ff;
	logic [3:0] pre_cnt_ff;
	logic [15:0] tx_crc_ff;
	// Ready to the source drops only while the queue holds QUEUE_DEPTH bytes
	data_queue #(.WIDTH(9), .DEPTH(QUEUE_DEPTH)) u_queue (
		.clock(clock),
		.rst(rst),
		.in_valid(tx_in_valid),
		.in_data({tx_in_last, tx_in_data}),
		.in_ready(tx_in_ready),
		.out_valid(q_valid),
		.out_data(q_data),
		.out_ready(q_pop)
	);
	assign advance = !tx_out_valid || tx_out_ready;
	assign q_pop = advance && ((tx_state_ff == TX_DATA) ||
		(tx_state_ff == TX_ENDLESS && tx_test == TEST_LOOP));
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ser_sync_ff <= 3'h0;
			ser_stable_ff <= 1'b0;
			ser_shift_ff <= 8'h00;
		end
		else
		begin
			ser_sync_ff <= {ser_sync_ff[1:0], tx_serial_pin};
			if (ser_sync_ff[1] == ser_sync_ff[2])
				ser_stable_ff <= ser_sync_ff[2];
			ser_shift_ff <= {ser_stable_ff, ser_shift_ff[7:1]};
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			tx_state_ff <= TX_IDLE;
			pre_cnt_ff <= 4'h0;
			tx_crc_ff <= 16'h0000;
			tx_out_valid <= 1'b0;
			tx_out_data <= 8'h00;
		end
		else if (tx_stop)
		begin
			tx_state_ff <= TX_IDLE;
			tx_out_valid <= 1'b0;
		end
		else if (advance)
		begin
			tx_out_valid <= 1'b0;
			unique case (tx_state_ff)
				TX_IDLE:
				begin
					if (tx_start)
					begin
						tx_state_ff <= TX_PREAMBLE;
						pre_cnt_ff <= mdm0l_ff[3:0];
						tx_crc_ff <= 16'h0000;
					end
				end
				TX_PREAMBLE:
				begin
					tx_out_valid <= 1'b1;
					tx_out_data <= 8'h00;
					pre_cnt_ff <= pre_cnt_ff - 4'h1;
					if (pre_cnt_ff == 4'h0)
						tx_state_ff <= (tx_test == TEST_NORMAL) ? TX_DATA : TX_ENDLESS;
				end
				TX_DATA:
				begin
					if (q_valid)
					begin
						tx_out_valid <= 1'b1;
						tx_out_data <= q_data[7:0];
						tx_crc_ff <= crc_byte(tx_crc_ff, q_data[7:0]);
						if (q_data[8])
							tx_state_ff <= mdm0l_ff[AUTO_CRC_BIT] ? TX_CRC_LOW : TX_IDLE;
					end
				end
				TX_CRC_LOW:
				begin
					tx_out_valid <= 1'b1;
					tx_out_data <= tx_crc_ff[7:0];
					tx_state_ff <= TX_CRC_HIGH;
				end
				TX_CRC_HIGH:
				begin
					tx_out_valid <= 1'b1;
					tx_out_data <= tx_crc_ff[15:8];
					tx_state_ff <= TX_IDLE;
				end
				TX_ENDLESS:
				begin
					tx_out_valid <= 1'b1;
					unique case (tx_test)
						TEST_SERIAL: tx_out_data <= ser_shift_ff;
						// On underflow the last byte repeats rather than stopping the stream
						TEST_LOOP: tx_out_data <= q_valid ? q_data[7:0] : tx_out_data;
						TEST_RANDOM:
						begin
							tx_crc_ff <= crc_byte(tx_crc_ff, RANDOM_FEED);
							tx_out_data <= tx_crc_ff[7:0];
						end
						default: tx_out_data <= 8'h00;
					endcase
				end
			endcase
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			tx_active <= 1'b0;
		else
			tx_active <= (tx_state_ff != TX_IDLE);
	end

	// ==========================================================
	// Receive path
	logic [1:0] rx_idx_ff;
	logic [15:0] rx_crc_ff;
	logic [15:0] rx_crc_next;
	logic ack_req_ff;
	logic rx_end;
	logic [7:0] rx_ser_ff;
	assign rx_crc_next = crc_byte(rx_crc_ff, rx_in_data);
	// Frames in the endless test modes never close
	assign rx_end = rx_busy && rx_in_valid && rx_in_last && (rx_test != TEST_SERIAL) && (rx_test != TEST_LOOP);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rx_busy <= 1'b0;
			rx_idx_ff <= 2'h0;
			rx_crc_ff <= 16'h0000;
			ack_req_ff <= 1'b0;
			rx_frame_done <= 1'b0;
			rx_crc_ok <= 1'b0;
		end
		else
		begin
			rx_frame_done <= rx_end;
			if (rx_in_sfd)
			begin
				rx_busy <= 1'b1;
				rx_idx_ff <= 2'h0;
				rx_crc_ff <= 16'h0000;
			end
			else if (rx_busy && rx_in_valid)
			begin
				if (rx_idx_ff != 2'h3)
					rx_idx_ff <= rx_idx_ff + 2'h1;
				if (rx_idx_ff != 2'h0)
					rx_crc_ff <= rx_crc_next;
				if (rx_idx_ff == 2'h1)
					ack_req_ff <= rx_in_data[ACK_REQUEST_BIT];
				if (rx_end)
				begin
					rx_busy <= 1'b0;
					rx_crc_ok <= mdm0l_ff[AUTO_CRC_BIT] && (rx_crc_next == 16'h0000);
				end
			end
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			rx_out_valid <= 1'b0;
			rx_out_data <= 8'h00;
			rx_ser_ff <= 8'h00;
			rx_serial_pin <= 1'b0;
			rx_overflow <= 1'b0;
		end
		else
		begin
			rx_out_valid <= rx_busy && rx_in_valid && (rx_test != TEST_SERIAL);
			rx_out_data <= rx_in_data;
			// A byte arriving inside eight cycles cuts the previous one short
			if (rx_busy && rx_in_valid && rx_test == TEST_SERIAL)
				rx_ser_ff <= rx_in_data;
			else
				rx_ser_ff <= {1'b0, rx_ser_ff[7:1]};
			rx_serial_pin <= rx_ser_ff[0];
			if (rx_busy && rx_in_valid && receive_queue_full && rx_test != TEST_LOOP && rx_test != TEST_SERIAL)
				rx_overflow <= 1'b1;
			else if (rx_in_sfd)
				rx_overflow <= 1'b0;
		end
	end

	// ==========================================================
	// Acknowledge timing
	logic [10:0] sym_div_ff;
	logic sym_tick;
	logic [4:0] slot_phase_ff;
	logic [4:0] nxt_slot_phase;
	logic [5:0] ack_since_ff;
	logic [5:0] nxt_since;
	logic ack_wait_ff;
	logic eligible;
	assign sym_tick = (sym_div_ff == 11'(SYMBOL_CYCLES - 1));
	assign nxt_slot_phase = (slot_phase_ff == SLOT_SYMBOLS - 5'h1) ? 5'h00 : slot_phase_ff + 5'h01;
	assign nxt_since = (ack_since_ff == 6'h3F) ? ack_since_ff : ack_since_ff + 6'h01;
	assign eligible = mdm0l_ff[AUTO_ACK_BIT] && (!address_decode_enable || address_match) && ack_req_ff &&
		(rx_crc_next == 16'h0000);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sym_div_ff <= 11'h000;
			slot_phase_ff <= 5'h00;
		end
		else if (rx_in_sfd)
		begin
			sym_div_ff <= 11'h000;
			slot_phase_ff <= 5'h00;
		end
		else
		begin
			sym_div_ff <= sym_tick ? 11'h000 : sym_div_ff + 11'h001;
			if (sym_tick)
				slot_phase_ff <= nxt_slot_phase;
		end
	end
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			ack_wait_ff <= 1'b0;
			ack_since_ff <= 6'h00;
			ack_send <= 1'b0;
		end
		else
		begin
			ack_send <= 1'b0;
			if (rx_end && eligible)
			begin
				ack_wait_ff <= 1'b1;
				ack_since_ff <= 6'h00;
			end
			else if (ack_wait_ff && sym_tick)
			begin
				ack_since_ff <= nxt_since;
				if ((!slotted && nxt_since == ACK_DELAY_SYMBOLS) ||
					(slotted && nxt_since >= ACK_DELAY_SYMBOLS && nxt_slot_phase == 5'h00))
				begin
					ack_send <= 1'b1;
					ack_wait_ff <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// Demodulator controls
	logic corr_met;
	logic corr_met_ff;
	assign corr_met = (correlator_value >= mdm1h_ff[4:0]);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			corr_met_ff <= 1'b0;
			sfd_search_enable <= 1'b0;
			dc_level_frozen <= 1'b0;
			phase_reversed <= 1'b0;
		end
		else
		begin
			corr_met_ff <= corr_met;
			// Stronger filter demands two samples in a row, trading latency for fewer false starts
			sfd_search_enable <= corr_met && (!mdm1h_ff[FILTER_LEVEL_BIT] || corr_met_ff);
			if (mdm1l_ff[DC_AVG_BIT] || rx_end)
				dc_level_frozen <= 1'b0;
			else if (preamble_match)
				dc_level_frozen <= 1'b1;
			phase_reversed <= mdm1l_ff[MOD_MODE_BIT];
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	property p_cca_rssi_busy;
		(cca_sel == CCA_RSSI) && (rssi_s >= thr_s) |=> !channel_clear;
	endproperty
	a_cca_rssi_busy: assert property (p_cca_rssi_busy) else $error("channel clear with strong signal");
	property p_cca_no_rx;
		(cca_sel == CCA_NO_RX) |=> (channel_clear == !$past(rx_busy));
	endproperty
	a_cca_no_rx: assert property (p_cca_no_rx) else $error("mode 10 clear does not follow reception");
	property p_cca_both;
		(cca_sel == CCA_BOTH) && rx_busy |=> !channel_clear;
	endproperty
	a_cca_both: assert property (p_cca_both) else $error("mode 11 clear during reception");
	property p_crc_low;
		(tx_state_ff == TX_CRC_LOW) && advance && !tx_stop |=> tx_out_valid && (tx_out_data == $past(tx_crc_ff[7:0]));
	endproperty
	a_crc_low: assert property (p_crc_low) else $error("checksum low byte wrong");
	property p_ack_unslotted;
		$rose(ack_send) && !slotted |-> (ack_since_ff == ACK_DELAY_SYMBOLS);
	endproperty
	a_ack_unslotted: assert property (p_ack_unslotted) else $error("ack not at 12 symbols");
	property p_ack_slotted;
		ack_send && $past(slotted) |-> (slot_phase_ff == 5'h00) && (ack_since_ff >= ACK_DELAY_SYMBOLS);
	endproperty
	a_ack_slotted: assert property (p_ack_slotted) else $error("slotted ack off slot boundary");
	property p_corr_gate;
		sfd_search_enable |-> $past(corr_met);
	endproperty
	a_corr_gate: assert property (p_corr_gate) else $error("search enabled below threshold");
	property p_loop_endless;
		(tx_state_ff == TX_ENDLESS) && !tx_stop |=> (tx_state_ff == TX_ENDLESS);
	endproperty
	a_loop_endless: assert property (p_loop_endless) else $error("endless transmit ended");
	property p_reserved_zero;
		xdata_rd && (xdata_addr == ADDR_MODEM_CONTROL_1_LOW) |=> (xdata_rdata[7:6] == 2'h0);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");
	c_ack: cover property (ack_send);
	c_crc_ok: cover property (rx_frame_done && rx_crc_ok);
	c_crc_high: cover property (tx_state_ff == TX_CRC_HIGH && advance);
	c_clear: cover property ($rose(channel_clear));
endmodule
`default_nettype wire

//--- logic/radio_modem_pkg.sv
// Constants, field layout and reset values for the radio modem control block
// What this block does
// - Mode 01: clear when signal below threshold minus hysteresis, busy at or above threshold
// - Mode 10: clear whenever no packet is being received; mode 00 is reserved
// - Mode 11 (reset): clear needs low signal and no reception; busy otherwise
// - With checksum on, transmitter appends a 16-bit ITU-T CRC after the last byte
// - With checksum on, receiver recomputes the CRC and flags the frame valid or not
// - Unslotted auto acknowledge goes out 12 symbol periods after an eligible frame
// - Slotted acknowledge waits for a 20-symbol slot boundary, 12 to 31 symbols later
// - Preamble sends length field plus one zero bytes before the sync word
// - Preamble length resets to 0010, three zero bytes
// - Filter level 1 applies stronger correlation filtering; 0 keeps the legacy filter
// - Correlator output must meet the 5-bit threshold, reset 0x10, before delimiter search
// - DC average bit 0 freezes the DC level at preamble match; 1 keeps updating
// - Modulation bit set selects reversed phase for transmit and receive
// - Transmit test 00 sends queue frames; 01 sends serial input data endlessly
// - Transmit test 10 drains the queue without end, repeating the last byte on underflow
// - Transmit test 11 sends endless pseudo-random data from the CRC generator
// - Receive test 00 stores into the receive queue; 01 drives received data onto a pin
// - Receive test 10 writes the queue endlessly ignoring overflow; 11 is reserved
// - Upper two bits of the second modem control low register read as zero
// - Hysteresis is a 3-bit value in dB subtracted from the threshold
// - Threshold is a signed two's complement value compared with signal strength
// - Address recognition gates auto acknowledge only while its enable bit is 1
package radio_modem_pkg;
	// ==========================================================
	// Register map
	localparam logic [15:0] ADDR_MODEM_CONTROL_0_LOW = 16'hDF03;
	localparam logic [15:0] ADDR_MODEM_CONTROL_1_HIGH = 16'hDF04;
	localparam logic [15:0] ADDR_MODEM_CONTROL_1_LOW = 16'hDF05;
	localparam logic [7:0] RST_MODEM_CONTROL_0_LOW = 8'hE2;
	localparam logic [7:0] RST_MODEM_CONTROL_1_HIGH = 8'h30;
	localparam logic [7:0] RST_MODEM_CONTROL_1_LOW = 8'h00;
	// ==========================================================
	// Field positions
	localparam int CCA_SEL_LSB = 6;
	localparam int AUTO_CRC_BIT = 5;
	localparam int AUTO_ACK_BIT = 4;
	localparam int SLOTTED_ACK_BIT = 7;
	localparam int FILTER_LEVEL_BIT = 5;
	localparam int DC_AVG_BIT = 5;
	localparam int MOD_MODE_BIT = 4;
	localparam int TX_TEST_LSB = 2;
	localparam int ACK_REQUEST_BIT = 5;
	localparam logic [1:0] CCA_RSSI = 2'h1;
	localparam logic [1:0] CCA_NO_RX = 2'h2;
	localparam logic [1:0] CCA_BOTH = 2'h3;
	localparam logic [1:0] TEST_NORMAL = 2'h0;
	localparam logic [1:0] TEST_SERIAL = 2'h1;
	localparam logic [1:0] TEST_LOOP = 2'h2;
	localparam logic [1:0] TEST_RANDOM = 2'h3;
	// ==========================================================
	// Timing and checksum
	localparam int CLOCK_NS = 10;
	localparam int SYMBOL_NS = 16000;
	localparam int SYMBOL_CYCLES = SYMBOL_NS / CLOCK_NS;
	localparam logic [5:0] ACK_DELAY_SYMBOLS = 6'h0C;
	localparam logic [4:0] SLOT_SYMBOLS = 5'h14;
	localparam logic [15:0] CRC_POLY_REFLECTED = 16'h8408;
	localparam logic [7:0] RANDOM_FEED = 8'hFF;
	typedef enum logic [2:0] {TX_IDLE, TX_PREAMBLE, TX_DATA, TX_CRC_LOW, TX_CRC_HIGH, TX_ENDLESS} tx_state_t;
endpackage

//--- tb/radio_peer.sv
// Over-the-air peer model: sink for the transmit byte stream, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module radio_peer (
	input wire logic clock,
	input wire logic rst,
	input wire logic slow,
	output logic tx_out_ready
);
	// ==========================================================
	// Acceptance pacing
	logic [1:0] pace_ff;
	// Slow mode is ready one cycle in four, so every byte must stand until taken
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pace_ff <= 2'h0;
		else
			pace_ff <= pace_ff + 2'h1;
	end
	assign tx_out_ready = !slow || (pace_ff == 2'h3);
endmodule
`default_nettype wire

//--- tb/tb_radio_modem_control.sv
// Self-checking bench for the radio modem control block
`timescale 1ns/10ps
`default_nettype none
module tb_radio_modem_control;
	import radio_modem_pkg::*;
	// ==========================================================
	// Signals
	logic clock = 0, rst = 1, xdata_wr = 0, xdata_rd = 0, tx_start = 0, tx_stop = 0, slow = 0, address_match = 1;
	logic tx_in_valid = 0, tx_in_last = 0, rx_in_sfd = 0, rx_in_valid = 0, rx_in_last = 0, preamble_match = 0;
	logic [15:0] xdata_addr = 0;
	logic [7:0] xdata_wdata = 0, clear_channel_threshold = 0, rssi_value = 0, tx_in_data = 0, rx_in_data = 0;
	logic [4:0] correlator_value = 0;
	logic [7:0] xdata_rdata, tx_out_data, rx_out_data;
	logic tx_in_ready, channel_clear, tx_out_valid, tx_out_ready, tx_active, rx_out_valid, rx_serial_pin;
	logic rx_busy, rx_frame_done, rx_crc_ok, rx_overflow, ack_send, sfd_search_enable, dc_level_frozen;
	logic phase_reversed;
	int num_errors = 0, checks = 0;
	radio_modem_control #(.QUEUE_DEPTH(4)) dut (.clock(clock), .rst(rst), .xdata_addr(xdata_addr),
		.xdata_wr(xdata_wr), .xdata_rd(xdata_rd), .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata),
		.clear_channel_hysteresis(3'h2), .clear_channel_threshold(clear_channel_threshold),
		.rssi_value(rssi_value), .address_decode_enable(1'b1), .address_match(address_match),
		.channel_clear(channel_clear), .tx_start(tx_start), .tx_stop(tx_stop), .tx_in_valid(tx_in_valid),
		.tx_in_data(tx_in_data), .tx_in_last(tx_in_last), .tx_in_ready(tx_in_ready), .tx_serial_pin(1'b0),
		.tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data), .tx_out_ready(tx_out_ready),
		.tx_active(tx_active), .rx_in_sfd(rx_in_sfd), .rx_in_valid(rx_in_valid), .rx_in_data(rx_in_data),
		.rx_in_last(rx_in_last), .receive_queue_full(1'b0), .rx_out_valid(rx_out_valid),
		.rx_out_data(rx_out_data), .rx_serial_pin(rx_serial_pin), .rx_busy(rx_busy),
		.rx_frame_done(rx_frame_done), .rx_crc_ok(rx_crc_ok), .rx_overflow(rx_overflow), .ack_send(ack_send),
		.correlator_value(correlator_value), .preamble_match(preamble_match),
		.sfd_search_enable(sfd_search_enable), .dc_level_frozen(dc_level_frozen),
		.phase_reversed(phase_reversed));
	radio_peer peer (.clock(clock), .rst(rst), .slow(slow), .tx_out_ready(tx_out_ready));
	initial
	begin
		forever #5 clock = ~clock;
	end
	// ==========================================================
	// Shared tasks
	task test_done;
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task fail(input string what);
		num_errors++;
		$display("wrong value %s expected done seen timeout", what);
		test_done();
	endtask
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clock);
		xdata_addr = a;
		xdata_wdata = d;
		xdata_wr = 1;
		@(negedge clock);
		xdata_wr = 0;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(negedge clock);
		xdata_addr = a;
		xdata_rd = 1;
		@(negedge clock);
		xdata_rd = 0;
		@(negedge clock);
		check("register", xdata_rdata, e);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clock);
		s = 1;
		@(negedge clock);
		s = 0;
	endtask
	// Reflected ITU-T checksum, zero start, low bit of each byte first
	function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
		for (int i = 0; i < 8; i++)
			c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
		return c;
	endfunction
	task collect(input int n, input logic [7:0] e[$]);
		int i, k;
		k = 0;
		for (i = 0; i < 400 && k < n; i++)
		begin
			@(negedge clock);
			if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1)
			begin
				if (k < e.size())
					check("tx byte", tx_out_data, e[k]);
				k++;
			end
		end
		if (k < n)
			fail("tx stream");
	endtask
	task rx_frame(input logic [7:0] fc, input logic good);
		logic [15:0] c;
		c = crc_step(crc_step(16'h0000, fc), 8'h5A);
		pulse(rx_in_sfd);
		check("rx busy", rx_busy, 1);
		rx_in_valid = 1;
		rx_in_data = 8'h04;
		@(negedge clock);
		rx_in_data = fc;
		@(negedge clock);
		rx_in_data = 8'h5A;
		@(negedge clock);
		rx_in_data = c[7:0];
		@(negedge clock);
		rx_in_data = c[15:8] ^ {7'h00, ~good};
		rx_in_last = 1;
		@(negedge clock);
		rx_in_valid = 0;
		rx_in_last = 0;
		check("frame done", rx_frame_done, 1);
		check("crc ok", rx_crc_ok, good);
		check("rx out", {rx_out_valid, rx_out_data}, {1'b1, c[15:8] ^ {7'h00, ~good}});
	endtask
	task cc(input logic [7:0] r, input logic e);
		rssi_value = r;
		repeat (3) @(negedge clock);
		check("channel clear", channel_clear, e);
	endtask
	// A refusal passes lo = hi = lim: no pulse may come inside the whole window
	task wait_ack(input int lo, input int hi, input int lim);
		int i;
		for (i = 0; i < lim && ack_send !== 1'b1; i++)
			@(negedge clock);
		if (hi < lim && i == lim)
			fail("ack");
		check("ack time", (i >= lo && i <= hi), 1);
	endtask
	// ==========================================================
	// Scenarios
	task regs;
		rd(ADDR_MODEM_CONTROL_0_LOW, 8'hE2);
		rd(ADDR_MODEM_CONTROL_1_HIGH, 8'h30);
		rd(ADDR_MODEM_CONTROL_1_LOW, 8'h00);
		wr(ADDR_MODEM_CONTROL_1_LOW, 8'hFF);
		rd(ADDR_MODEM_CONTROL_1_LOW, 8'h3F);
		wr(ADDR_MODEM_CONTROL_1_LOW, 8'h00);
		rd(16'hDF00, 8'h00);
	endtask
	task clear_channel;
		cc(8'hF8, 1);
		cc(8'hFF, 1);
		cc(8'h00, 0);
		cc(8'hFF, 0);
		wr(ADDR_MODEM_CONTROL_0_LOW, 8'hA2);
		cc(8'h00, 1);
		wr(ADDR_MODEM_CONTROL_0_LOW, 8'h62);
		clear_channel_threshold = 8'h10;
		cc(8'h0F, 0);
		cc(8'h0D, 1);
		cc(8'h10, 0);
		clear_channel_threshold = 8'h00;
		wr(ADDR_MODEM_CONTROL_0_LOW, 8'hE2);
	endtask
	task demod;
		correlator_value = 5'h0F;
		repeat (4) @(negedge clock);
		check("search", sfd_search_enable, 0);
		correlator_value = 5'h10;
		repeat (4) @(negedge clock);
		check("search", sfd_search_enable, 1);
		pulse(preamble_match);
		@(negedge clock);
		check("dc frozen", dc_level_frozen, 1);
		wr(ADDR_MODEM_CONTROL_1_LOW, 8'h30);
		pulse(preamble_match);
		@(negedge clock);
		check("dc frozen", dc_level_frozen, 0);
		check("phase", phase_reversed, 1);
		wr(ADDR_MODEM_CONTROL_1_LOW, 8'h00);
		@(negedge clock);
		check("phase", phase_reversed, 0);
	endtask
	task tx_frame;
		logic [15:0] c;
		logic [7:0] e[$];
		c = 16'h0000;
		e = {8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clock);
			tx_in_valid = 1;
			tx_in_data = 8'hA1 + 8'h11 * i;
			tx_in_last = (i == 3);
			c = crc_step(c, tx_in_data);
			e.push_back(tx_in_data);
			@(negedge clock);
			tx_in_valid = 0;
		end
		check("queue ready", tx_in_ready, 0);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		slow = 1;
		pulse(tx_start);
		collect(9, e);
		repeat (6) @(negedge clock);
		check("tx valid", tx_out_valid, 0);
		check("queue ready", tx_in_ready, 1);
		slow = 0;
	endtask
	task tx_test;
		logic [15:0] c;
		logic [7:0] z[$];
		for (int m = 1; m < 4; m++)
		begin
			// Serial input and the empty looping queue both give zeros; random mode walks the checksum
			z = {};
			c = 16'h0000;
			for (int i = 0; i < 12; i++)
			begin
				z.push_back((m == 3 && i > 2) ? c[7:0] : 8'h00);
				if (m == 3 && i > 2)
					c = crc_step(c, RANDOM_FEED);
			end
			wr(ADDR_MODEM_CONTROL_1_LOW, 8'(m << TX_TEST_LSB));
			pulse(tx_start);
			collect(12, z);
			pulse(tx_stop);
			repeat (3) @(negedge clock);
			check("tx active", tx_active, 0);
		end
		wr(ADDR_MODEM_CONTROL_1_LOW, 8'h00);
	endtask
	task ack;
		wr(ADDR_MODEM_CONTROL_0_LOW, 8'hF2);
		rx_frame(8'h21, 1);
		wait_ack(17599, 19201, 20000);
		rx_frame(8'h21, 0);
		wait_ack(20000, 20000, 20000);
		address_match = 0;
		rx_frame(8'h21, 1);
		wait_ack(20000, 20000, 20000);
		address_match = 1;
		wr(ADDR_MODEM_CONTROL_1_HIGH, 8'hB0);
		rx_frame(8'h21, 1);
		// Twenty symbols after the delimiter is the first slot boundary past twelve
		wait_ack(30395, 32001, 33000);
		wr(ADDR_MODEM_CONTROL_1_HIGH, 8'h30);
		wr(ADDR_MODEM_CONTROL_0_LOW, 8'hE2);
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (2) @(negedge clock);
		rst = 0;
		regs();
		clear_channel();
		demod();
		tx_frame();
		tx_test();
		ack();
		test_done();
	end
endmodule
`default_nettype wire
